// ### mpbc_flow_ctrl.v
// mac pause frame and back-pressure flow control with ahb-lite register
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`include "mpbc_consts.vh"
module mpbc_flow_ctrl (
  input  wire        hclk,            // bus and mac clock
  input  wire        hresetn,         // async reset, active low
  input  wire        hsel,            // slave select
  input  wire [31:0] haddr,           // byte address
  input  wire [1:0]  htrans,          // transfer type
  input  wire        hwrite,          // write when high
  input  wire [2:0]  hsize,           // transfer size
  input  wire        hready,          // bus ready in
  input  wire [31:0] hwdata,          // write data
  output wire [31:0] hrdata,          // read data
  output wire        hreadyout,       // slave ready
  output wire        hresp,           // always okay
  input  wire        full_duplex,     // link mode, from mac config
  input  wire        speed_100,       // link speed, high for 100m
  input  wire        tx_enabled,      // transmitter enabled
  input  wire        pause_request,   // pulse: send one pause frame
  input  wire        rx_congested,    // level: receive side wants back pressure
  input  wire        rx_frame_end,    // pulse: received frame complete
  input  wire        rx_is_pause,     // valid pause frame at frame end
  input  wire [15:0] rx_pause_time,   // decoded pause time
  input  wire        rx_filter_mode,  // address filter mode claims the filter bit
  input  wire        rx_filter_value, // filter bit from address filtering
  input  wire [31:0] rx_status_in,    // receive status from mac
  output reg  [31:0] rx_status_out,   // receive status with filter bit
  output reg         rx_status_valid, // pulse: status_out valid
  output reg         pause_tx_start,  // pulse: start pause frame
  output reg  [47:0] pause_da,        // pause frame destination
  output reg  [15:0] pause_etype,     // pause frame type field
  output reg  [15:0] pause_opcode,    // pause frame opcode
  output reg  [15:0] pause_time_out,  // pause frame time field
  input  wire        pause_tx_done,   // pulse: pause frame on the wire
  output reg         back_pressure,   // half duplex jam request
  output reg         tx_hold          // transmitter held off by received pause
);

  // ---------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------
  reg        wr_pend_ff;
  reg        rd_pend_ff;
  reg        hit_ff;
  reg [15:0] pause_time_value_ff;
  reg        flag_received_pause_ff;
  reg        flow_ctrl_enable_ff;
  reg        pause_tx_busy_ff;
  reg        bp_busy_ff;
  reg        pf_busy_ff;
  reg [15:0] pause_cnt_ff;
  reg [9:0]  slot_cnt_ff;
  reg [31:0] rdata_ff;

  wire addr_ok = (haddr == `MPBC_ADDR_FLOW);
  wire take    = hsel && hready && htrans[1];

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_ff;

  wire fd_on = full_duplex && flow_ctrl_enable_ff; // R15
  wire hd_on = !full_duplex && flow_ctrl_enable_ff && tx_enabled; // R17 R18

  function [9:0] slot_len;
    input fast;
    begin
      slot_len = fast ? `MPBC_SLOT_CLKS_100 : `MPBC_SLOT_CLKS_10; // R19
    end
  endfunction

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      hit_ff     <= 1'b0;
      rdata_ff   <= 32'h00000000;
    end else begin
      wr_pend_ff <= take && hwrite;
      rd_pend_ff <= take && !hwrite;
      hit_ff     <= take && addr_ok;
      if (take && !hwrite)
        rdata_ff <= addr_ok ? {pause_time_value_ff, 13'h0000, flag_received_pause_ff,
                               flow_ctrl_enable_ff, pause_tx_busy_ff} : 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // flow-control register
  // ---------------------------------------------------------------
  // busy bit is read only; writes ignore it since software writes zero there
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pause_time_value_ff    <= 16'h0000; // R1
      flag_received_pause_ff <= 1'b0; // R1
      flow_ctrl_enable_ff    <= 1'b0; // R1
    end else if (wr_pend_ff && hit_ff) begin
      pause_time_value_ff    <= hwdata[`MPBC_PT_HI:`MPBC_PT_LO];
      flag_received_pause_ff <= hwdata[`MPBC_BIT_PASS];
      flow_ctrl_enable_ff    <= hwdata[`MPBC_BIT_ENABLE];
    end
  end

  // ---------------------------------------------------------------
  // pause transmit and back pressure
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pf_busy_ff     <= 1'b0;
      bp_busy_ff     <= 1'b0;
      pause_tx_busy_ff <= 1'b0;
      pause_tx_start <= 1'b0;
      pause_da       <= 48'h000000000000;
      pause_etype    <= 16'h0000;
      pause_opcode   <= 16'h0000;
      pause_time_out <= 16'h0000;
      back_pressure  <= 1'b0;
    end else begin
      pause_tx_start <= 1'b0;
      if (pf_busy_ff && pause_tx_done)
        pf_busy_ff <= 1'b0; // R5
      else if (!pf_busy_ff && pause_request && fd_on && tx_enabled) begin // R18
        pf_busy_ff     <= 1'b1; // R5
        pause_tx_start <= 1'b1;
        pause_da       <= `MPBC_PAUSE_DA; // R3
        pause_etype    <= `MPBC_PAUSE_ETYPE; // R3
        pause_opcode   <= `MPBC_PAUSE_OPCODE; // R3
        pause_time_out <= pause_time_value_ff; // R2
      end
      bp_busy_ff       <= hd_on && rx_congested; // R17
      back_pressure    <= hd_on && rx_congested; // R6 R18
      pause_tx_busy_ff <= (pf_busy_ff && !pause_tx_done) ||
                          (!pf_busy_ff && pause_request && fd_on && tx_enabled) ||
                          (hd_on && rx_congested); // R5 R6
    end
  end

  // ---------------------------------------------------------------
  // received pause and status
  // ---------------------------------------------------------------
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pause_cnt_ff    <= 16'h0000;
      slot_cnt_ff     <= 10'h000;
      tx_hold         <= 1'b0;
      rx_status_out   <= 32'h00000000;
      rx_status_valid <= 1'b0;
    end else begin
      rx_status_valid <= rx_frame_end; // R11
      if (rx_frame_end) begin
        rx_status_out <= rx_status_in;
        if (rx_filter_mode)
          rx_status_out[`MPBC_STAT_FILTER] <= rx_filter_value; // R13
        else
          rx_status_out[`MPBC_STAT_FILTER] <= flag_received_pause_ff && rx_is_pause; // R9 R10
      end
      if (rx_frame_end && rx_is_pause && fd_on) begin // R14 R16
        pause_cnt_ff <= rx_pause_time;
        slot_cnt_ff  <= slot_len(speed_100) - 10'd1;
        tx_hold      <= (rx_pause_time != 16'h0000);
      end else if (!fd_on) begin
        pause_cnt_ff <= 16'h0000; // R16
        tx_hold      <= 1'b0;
      end else if (pause_cnt_ff != 16'h0000) begin
        if (slot_cnt_ff == 10'h000) begin
          pause_cnt_ff <= pause_cnt_ff - 16'h0001; // R19
          slot_cnt_ff  <= slot_len(speed_100) - 10'd1;
          tx_hold      <= (pause_cnt_ff != 16'h0001);
        end else
          slot_cnt_ff <= slot_cnt_ff - 10'd1;
      end
    end
  end

endmodule // mpbc_flow_ctrl

// ### mpbc_consts.vh
// constants and register layout for the mac pause / back-pressure controller
//
// Behaviour
// R1: flow-control register resets to all zero; everything starts inactive.
// R2: transmitted pause frame carries pause_time_value bits 31-16.
// R3: pause frame fields follow the standard full-duplex mac control pause format.
// R4: software programs pause_time_value before enabling full-duplex flow control.
// R5: full duplex: busy high while pause frame transmits, zero when done.
// R6: half duplex: busy high while back pressure is asserted.
// R7: software reads busy as zero before writing the register.
// R8: software always writes zero into the busy bit.
// R9: flagging set: packet-filter status bit set for each valid received pause frame.
// R10: flagging clear: packet-filter status bit cleared.
// R11: every received frame's data goes to the application regardless of flagging.
// R12: application keeps or discards frames from their status word.
// R13: active address-filtering modes such as promiscuous override the flagging setting.
// R14: full duplex enabled: decode pause frames, stop transmitter for time times slot.
// R15: received pause acts only in full duplex with enable set.
// R16: enable clear: no control-frame inspection and no pause applied; the filter bit still marks pause frames when flagging is set.
// R17: half duplex: enable bit turns on back pressure instead.
// R18: no pause frames or back pressure while transmitter is disabled.
// R19: each pause unit is one 512-bit-time slot, counted down to zero; at 100m the code counts 52 clocks per unit, 520 bit times.
`ifndef MPBC_CONSTS_VH
`define MPBC_CONSTS_VH
// printed offsets are word indices; the byte address is four times the index
`define MPBC_IDX_FLOW       8'h08
`define MPBC_ADDR_FLOW      32'h00000020
`define MPBC_FLOW_RESET     32'h00000000
`define MPBC_BIT_BUSY       0
`define MPBC_BIT_ENABLE     1
`define MPBC_BIT_PASS       2
`define MPBC_PT_HI          31
`define MPBC_PT_LO          16
`define MPBC_STAT_FILTER    2
`define MPBC_SLOT_BITS      512
// bit times per clock: 10 mhz clock, 100 ns per 10 bits at 100m, 1 bit at 10m
`define MPBC_BITS_PER_CLK_100 10
`define MPBC_BITS_PER_CLK_10  1
// 51.2 clocks at 100m rounded up, so a pause never ends early
`define MPBC_SLOT_CLKS_100  10'd52
`define MPBC_SLOT_CLKS_10   10'd512
`define MPBC_PAUSE_OPCODE   16'h0001
`define MPBC_PAUSE_ETYPE    16'h8808
`define MPBC_PAUSE_DA       48'h0180c2000001
`endif

// ### mpbc_checker.sv
// port checker for mpbc_flow_ctrl
`timescale 1ns/1ps
module mpbc_checker (
  input wire hclk, hresetn, full_duplex, tx_enabled, rx_congested, rx_frame_end, rx_is_pause, rx_filter_mode,
  input wire rx_filter_value, rx_status_valid, pause_tx_start, back_pressure, tx_hold,
  input wire [15:0] rx_pause_time, pause_etype, pause_opcode,
  input wire [31:0] rx_status_in, rx_status_out,
  input wire [47:0] pause_da
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_hdr; pause_tx_start |-> {pause_da, pause_etype, pause_opcode} == 80'h0180c2000001_8808_0001; endproperty
  a_hdr: assert property (p_hdr) else $error("bad pause header");
  property p_off; !tx_enabled |=> !pause_tx_start && !back_pressure; endproperty
  a_off: assert property (p_off) else $error("flow action with tx off");
  property p_bp; $rose(back_pressure) |-> $past(!full_duplex && rx_congested && tx_enabled); endproperty
  a_bp: assert property (p_bp) else $error("back pressure without cause");
  property p_hold; $rose(tx_hold) |-> $past(rx_frame_end && rx_is_pause && full_duplex && rx_pause_time != 16'h0); endproperty
  a_hold: assert property (p_hold) else $error("hold without pause frame");
  property p_fd; tx_hold |-> $past(full_duplex); endproperty
  a_fd: assert property (p_fd) else $error("hold outside full duplex");
  property p_flt; rx_status_valid && !$past(rx_filter_mode) && !$past(rx_is_pause) |-> !rx_status_out[2]; endproperty
  a_flt: assert property (p_flt) else $error("filter bit set on plain frame");
  property p_mode; rx_status_valid && $past(rx_filter_mode) |-> rx_status_out[2] == $past(rx_filter_value); endproperty
  a_mode: assert property (p_mode) else $error("filter mode ignored");
  property p_pass; rx_status_valid |-> ((rx_status_out ^ $past(rx_status_in)) & 32'hfffffffb) == 32'h0; endproperty
  a_pass: assert property (p_pass) else $error("status bits altered");
  property p_valid; rx_frame_end |=> rx_status_valid; endproperty
  a_valid: assert property (p_valid) else $error("frame status not delivered");
  c_pause: cover property (pause_tx_start);
  c_hold: cover property ($rose(tx_hold));
  c_bp: cover property ($rose(back_pressure));
endmodule // mpbc_checker
bind mpbc_flow_ctrl mpbc_checker mpbc_checker_i (.*);

// ### mpbc_link_model.sv
// link-side model: ends each pause frame after link_dly clocks
`timescale 1ns/1ps
module mpbc_link_model (
  input  wire       hclk,           // mac clock
  input  wire       pause_tx_start, // frame begins
  input  wire [7:0] link_dly,       // clocks the frame occupies
  output reg        pause_tx_done   // pulse: frame on the wire
);
  initial pause_tx_done = 1'b0;
  always @(posedge hclk) begin
    if (pause_tx_start) begin
      repeat (link_dly) @(posedge hclk);
      pause_tx_done <= 1'b1;
      @(posedge hclk);
      pause_tx_done <= 1'b0;
    end
  end
endmodule // mpbc_link_model

// ### tb.sv
// self-checking bench for mpbc_flow_ctrl
`timescale 1ns/1ps
module tb;
  reg hclk, hresetn, hsel, hwrite, full_duplex, speed_100, tx_enabled, pause_request, rx_congested, rx_frame_end;
  reg rx_is_pause, rx_filter_mode, rx_filter_value, rd_dp;
  reg [1:0] htrans;
  reg [2:0] hsize;
  reg [7:0] link_dly;
  reg [15:0] rx_pause_time, pt, n;
  reg [31:0] haddr, hwdata, rx_status_in, seed;
  wire hreadyout, hresp, rx_status_valid, pause_tx_start, pause_tx_done, back_pressure, tx_hold;
  wire [15:0] pause_time_out;
  wire [31:0] hrdata, rx_status_out;
  int mismatches, cmp_count, hold_n;
  logic [31:0] rd_q[$], st_q[$], pt_q[$];
  mpbc_flow_ctrl mpbc_flow_ctrl_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout),
    .hwdata, .hrdata, .hreadyout, .hresp, .full_duplex, .speed_100, .tx_enabled, .pause_request, .rx_congested,
    .rx_frame_end, .rx_is_pause, .rx_pause_time, .rx_filter_mode, .rx_filter_value, .rx_status_in, .rx_status_out,
    .rx_status_valid, .pause_tx_start, .pause_da(), .pause_etype(), .pause_opcode(), .pause_time_out,
    .pause_tx_done, .back_pressure, .tx_hold);
  mpbc_link_model mpbc_link_model_i (.hclk, .pause_tx_start, .link_dly, .pause_tx_done);
  function automatic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic ph;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  // d is write data, or the expected read data
  task automatic bus(bit w, bit [31:0] a, bit [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    ph;
    htrans <= 2'h0;
    hwdata <= d;
    if (!w) rd_q.push_back(d);
    ph;
  endtask
  task automatic pz(bit go);
    if (go) pt_q.push_back({16'h0, pt});
    pause_request <= 1'b1;
    @(posedge hclk);
    pause_request <= 1'b0;
  endtask
  task automatic rxf(bit pz, bit m, bit v, bit [15:0] t, bit b);
    bit [31:0] r;
    r = xs();
    {rx_frame_end, rx_is_pause, rx_filter_mode, rx_filter_value, rx_pause_time, rx_status_in} <= {1'b1, pz, m, v, t, r};
    st_q.push_back({r[31:3], b, r[1:0]});
    @(posedge hclk);
    rx_frame_end <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (rd_dp) cmp("hrdata", rd_q.pop_front(), hrdata);
    if (rx_status_valid) cmp("rx_status", st_q.pop_front(), rx_status_out);
    if (pause_tx_start) cmp("pause_time", pt_q.pop_front(), {16'h0, pause_time_out});
    if (tx_hold) hold_n++;
    rd_dp <= hsel && htrans[1] && !hwrite && hreadyout;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    end_sim;
  end
  initial begin
    {hresetn, hsel, hwrite, full_duplex, tx_enabled, pause_request, rx_congested, rx_frame_end, rd_dp} = 9'h0;
    {rx_is_pause, rx_filter_mode, rx_filter_value, htrans, haddr, hwdata, rx_status_in, rx_pause_time} = 0;
    {speed_100, hsize, link_dly, seed} = {1'b1, 3'h2, 8'h28, 32'h1a996f4e};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    bus(0, 32'h20, 32'h0);
    bus(0, 32'h24, 32'h0);
    $display("test reset done");
    {pt, n} = xs();
    bus(1, 32'h20, {pt, 16'h6});
    full_duplex <= 1'b1;
    tx_enabled <= 1'b1;
    bus(0, 32'h20, {pt, 16'h6});
    pz(1);
    bus(0, 32'h20, {pt, 16'h7});
    repeat (50) @(posedge hclk);
    bus(0, 32'h20, {pt, 16'h6});
    link_dly <= 8'h1;
    pz(1);
    repeat (10) @(posedge hclk);
    tx_enabled <= 1'b0;
    pz(0);
    bus(0, 32'h20, {pt, 16'h6});
    $display("test pause send done");
    for (int s = 0; s < 2; s++) begin
      speed_100 <= s[0];
      n = 16'(xs() & 32'h3) + 16'h1;
      hold_n = 0;
      rxf(1, 0, 0, n, 1);
      repeat (2100) @(posedge hclk);
      cmp("hold", n * (s ? 52 : 512), hold_n);
    end
    rxf(0, 1, 1, 0, 1);
    rxf(1, 1, 0, 0, 0);
    rxf(0, 0, 0, 0, 0);
    bus(1, 32'h20, {pt, 16'h2});
    rxf(1, 0, 0, 0, 0);
    bus(1, 32'h20, 32'h0);
    hold_n = 0;
    rxf(1, 0, 0, 16'h5, 0);
    repeat (300) @(posedge hclk);
    cmp("hold", 0, hold_n);
    $display("test pause receive done");
    bus(1, 32'h20, {pt, 16'h2});
    {full_duplex, tx_enabled, rx_congested} <= 3'b011;
    repeat (2) @(posedge hclk);
    cmp("back_pressure", 1, back_pressure);
    bus(0, 32'h20, {pt, 16'h3});
    rx_congested <= 1'b0;
    repeat (3) @(posedge hclk);
    cmp("back_pressure", 0, back_pressure);
    bus(0, 32'h20, {pt, 16'h2});
    {tx_enabled, rx_congested} <= 2'b01;
    repeat (3) @(posedge hclk);
    cmp("back_pressure", 0, back_pressure);
    bus(0, 32'h20, {pt, 16'h2});
    $display("test back pressure done");
    end_sim;
  end
endmodule // tb
